// [design/count_prescaler.sv]
// Prescaler for the timer: turns count-clock ticks into counter increments.
// Assumes ticks are one-cycle pulses in the clk_sys domain.
`timescale 1ns/1ps
module count_prescaler (
    input wire logic clk_sys, // System clock.
    input wire logic rst_b, // Synchronous reset, active low.
    input wire logic clear, // Restarts the division.
    input wire logic tick, // Selected clock event.
    input wire logic [1:0] select, // Division ratio code.
    output logic inc // One-cycle increment pulse.
);
    import timer_one_pkg::*;
    logic [2:0] div_count;
    logic [2:0] next_div_count;
    logic [2:0] limit;

    // Next value and terminal detection for the divider.
    always_comb begin
        case (select)
            PS_DIV1: limit = 3'h0;
            PS_DIV2: limit = 3'h1;
            PS_DIV4: limit = 3'h3;
            PS_DIV8: limit = 3'h7;
            default: limit = 3'h0;
        endcase
        inc = tick && (div_count >= limit); // [R6]
        next_div_count = div_count;
        if (clear) begin
            next_div_count = 3'h0;
        end else if (tick) begin
            next_div_count = (div_count >= limit) ? 3'h0 : div_count + 3'h1;
        end
    end

    // Divider register.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            div_count <= 3'h0;
        end else begin
            div_count <= next_div_count;
        end
    end
endmodule

// [design/timer_one.sv]
// 16-bit timer/counter with prescaler, overflow interrupt and compare-unit clear.
// Assumes register strobes synchronous to clk_sys; read data valid the cycle after.
// Function
// [R1] Sixteen-bit up counter, readable and writable as high and low bytes.
// [R2] Overflow from FFFFh to 0000h sets the overflow interrupt flag.
// [R3] Compare unit special event trigger clears the count.
// [R4] Wide-access bit selects atomic 16-bit or independent byte access.
// [R5] Control bit 6 is read-only: system clock comes from secondary oscillator.
// [R6] Prescale field divides count clock by 1, 2, 4 or 8.
// [R7] Oscillator enable bit powers the secondary oscillator; cleared powers it down.
// [R8] External source: sync bit 1 passes clock raw, 0 synchronises it.
// [R9] Internal source ignores sync bit and counts the instruction clock.
// [R10] Source bit: 1 counts external pin rising edges, 0 counts Fosc/4.
// [R11] Run-enable bit set lets the counter advance; cleared stops it.
// [R12] Secondary oscillator may serve as system clock in power-managed modes.
// [R13] Status bit follows the actual clock source after oscillator failure.
// [R14] Writable control bits and status bit are zero after reset.
// [R15] Wide mode: low read latches high; high write staged until low write.
`timescale 1ns/1ps
module timer_one #(
    parameter int INSTR_DIV = 4 // Instruction clock divider from oscillator.
) (
    input wire logic clk_sys, // System clock, Fosc.
    input wire logic rst_b, // Synchronous reset, active low.
    input wire logic [timer_one_pkg::ADDR_W-1:0] reg_addr, // Register address.
    input wire logic [timer_one_pkg::DATA_W-1:0] reg_wdata, // Write data.
    input wire logic reg_write, // Write strobe.
    input wire logic reg_read, // Read strobe.
    output logic [timer_one_pkg::DATA_W-1:0] reg_rdata, // Read data, one cycle later.
    input wire logic ext_clock_pin, // External count clock.
    input wire logic compare_unit_trigger, // Special event trigger pulse.
    input wire logic sysclk_on_secondary, // Clock switch reports secondary source.
    output logic secondary_osc_enable, // Powers the secondary oscillator.
    output logic irq // Level interrupt.
);
    import timer_one_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////
    // State.
    logic [7:0] control;
    logic [7:0] next_control;
    logic [15:0] count;
    logic [15:0] next_count;
    logic [7:0] high_buffer;
    logic [7:0] next_high_buffer;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] next_irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] next_irq_mask;
    logic [7:0] next_rdata;
    logic sysclk_status;
    logic [1:0] instr_count;
    logic [1:0] next_instr_count;
    logic ext_meta;
    logic ext_sync;
    logic ext_sync_d;
    logic ext_raw_d;
    logic tick;
    logic inc;
    logic overflow;
    logic wr_low;
    logic wr_high;
    logic wr_ctrl;
    logic presc_clear;

    assign wr_low = reg_write && (reg_addr == OFF_COUNT_LOW);
    assign wr_high = reg_write && (reg_addr == OFF_COUNT_HIGH);
    assign wr_ctrl = reg_write && (reg_addr == OFF_CONTROL);

    ////////////////////////////////////////////////////////////////////////////////////
    // Count clock selection; the raw path still needs one flop to find the edge.
    always_comb begin
        next_instr_count = (instr_count == 2'(INSTR_DIV - 1)) ? 2'h0 : instr_count + 2'h1;
        if (!control[BIT_SRC]) begin
            tick = (instr_count == 2'h0); // [R9] [R10]
        end else if (control[BIT_SYNC_N]) begin
            tick = ext_clock_pin && !ext_raw_d; // [R8]
        end else begin
            tick = ext_sync && !ext_sync_d; // [R8] [R10]
        end
        tick = tick && control[BIT_RUN]; // [R11]
    end

    // Two-flop synchroniser; only the second stage feeds the edge detector.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            instr_count <= 2'h0;
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_sync_d <= 1'b0;
            ext_raw_d <= 1'b0;
        end else begin
            instr_count <= next_instr_count;
            ext_meta <= ext_clock_pin;
            ext_sync <= ext_meta;
            ext_sync_d <= ext_sync;
            ext_raw_d <= ext_clock_pin;
        end
    end

    assign presc_clear = wr_low || wr_high || compare_unit_trigger;

    count_prescaler u_prescaler (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clear(presc_clear),
        .tick(tick),
        .select(control[BIT_PS_HI:BIT_PS_LO]),
        .inc(inc)
    );

    ////////////////////////////////////////////////////////////////////////////////////
    // Counter, high-byte buffer and control register next values.
    always_comb begin
        next_count = count;
        next_high_buffer = high_buffer;
        next_control = control;
        overflow = 1'b0;
        if (inc) begin
            next_count = count + 16'h0001; // [R1]
            overflow = (count == COUNT_MAX); // [R2]
        end
        if (control[BIT_WIDE]) begin
            // Wide mode: high write is staged, low write commits both bytes.
            if (wr_high) begin
                next_high_buffer = reg_wdata; // [R15]
            end
            if (wr_low) begin
                next_count = {high_buffer, reg_wdata}; // [R4] [R15]
                overflow = 1'b0;
            end
            if (reg_read && reg_addr == OFF_COUNT_LOW) begin
                next_high_buffer = count[15:8]; // [R15]
            end
        end else begin
            if (wr_high) begin
                next_count[15:8] = reg_wdata; // [R1] [R4]
            end
            if (wr_low) begin
                next_count[7:0] = reg_wdata; // [R1] [R4]
            end
            if (wr_high || wr_low) begin
                overflow = 1'b0;
            end
        end
        if (compare_unit_trigger) begin
            next_count = COUNT_RESET; // [R3]
            overflow = 1'b0;
        end
        if (wr_ctrl) begin
            next_control = reg_wdata & CONTROL_WR_MASK; // [R5]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            count <= COUNT_RESET;
            high_buffer <= 8'h00;
            control <= CONTROL_RESET; // [R14]
            sysclk_status <= 1'b0; // [R14]
        end else begin
            count <= next_count;
            high_buffer <= next_high_buffer;
            control <= next_control;
            // Follows the live source one clock later, so a failed oscillator shows on the next cycle.
            sysclk_status <= sysclk_on_secondary; // [R5] [R12] [R13]
        end
    end

    // The oscillator pad is powered only while the enable bit is set.
    assign secondary_osc_enable = control[BIT_OSC_EN]; // [R7]

    ////////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and read data; a set beats a clear in the same cycle.
    always_comb begin
        next_irq_status = irq_status;
        next_irq_mask = irq_mask;
        if (reg_write && reg_addr == OFF_IRQ_STATUS) begin
            next_irq_status = irq_status & ~reg_wdata[IRQ_W-1:0];
        end
        if (reg_write && reg_addr == OFF_IRQ_MASK) begin
            next_irq_mask = reg_wdata[IRQ_W-1:0];
        end
        if (overflow) begin
            next_irq_status[IRQ_OVERFLOW] = 1'b1; // [R2]
        end
        if (compare_unit_trigger) begin
            next_irq_status[IRQ_SPECIAL] = 1'b1;
        end
        next_rdata = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                OFF_COUNT_LOW: next_rdata = count[7:0];
                OFF_COUNT_HIGH: next_rdata = control[BIT_WIDE] ? high_buffer : count[15:8];
                OFF_CONTROL: next_rdata = {control[7], sysclk_status, control[5:0]};
                OFF_IRQ_STATUS: next_rdata = {{(8 - IRQ_W){1'b0}}, irq_status};
                OFF_IRQ_MASK: next_rdata = {{(8 - IRQ_W){1'b0}}, irq_mask};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq_status <= '0;
            irq_mask <= '0;
            reg_rdata <= 8'h00;
        end else begin
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            reg_rdata <= next_rdata;
        end
    end

    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////////////////
    // Checks.
    overflow_sets_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R2]
        overflow |=> irq_status[IRQ_OVERFLOW]) else $error("overflow flag not set");
    trigger_clears_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R3]
        compare_unit_trigger |=> count == 16'h0000) else $error("trigger did not clear");
    stopped_holds_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R11]
        (!control[BIT_RUN] && !reg_write && !compare_unit_trigger) |=> $stable(count))
        else $error("stopped counter moved");
    count_steps_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R1]
        (inc && !reg_write && !compare_unit_trigger) |=> count == $past(count) + 16'h0001)
        else $error("count did not step");
    wide_commit_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R4]
        (wr_low && control[BIT_WIDE] && !compare_unit_trigger)
        |=> count == {$past(high_buffer), $past(reg_wdata)})
        else $error("wide write wrong");
    status_ro_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R5]
        wr_ctrl |=> control[BIT_SYSCLK] == 1'b0) else $error("status bit written");
    // The pad enable must follow what software wrote, not merely mirror the register.
    osc_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R7]
        wr_ctrl |=> secondary_osc_enable == $past(reg_wdata[BIT_OSC_EN]))
        else $error("osc enable wrong");
    div8_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R6]
        (inc && control[BIT_PS_HI:BIT_PS_LO] == PS_DIV8 && !control[BIT_SRC] && !reg_write
         && !compare_unit_trigger) |=> !inc [*8]) else $error("prescale 8 too fast");
    internal_rate_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R9]
        (tick && !control[BIT_SRC]) |=> !tick [*3]) else $error("internal tick too fast");
    status_track_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R13]
        1'b1 |=> sysclk_status == $past(sysclk_on_secondary))
        else $error("status not tracking");
endmodule

// [design/timer_one_pkg.sv]
// Package for the 16-bit timer/counter: register offsets, control fields, reset values.
// Assumes a single 200 MHz system clock and an 8-bit register port.
package timer_one_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    // Register offsets.
    localparam logic [2:0] OFF_COUNT_LOW = 3'h0;
    localparam logic [2:0] OFF_COUNT_HIGH = 3'h1;
    localparam logic [2:0] OFF_CONTROL = 3'h2;
    localparam logic [2:0] OFF_IRQ_STATUS = 3'h3;
    localparam logic [2:0] OFF_IRQ_MASK = 3'h4;
    // Control register fields.
    localparam int BIT_RUN = 0;
    localparam int BIT_SRC = 1;
    localparam int BIT_SYNC_N = 2;
    localparam int BIT_OSC_EN = 3;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_SYSCLK = 6;
    localparam int BIT_WIDE = 7;
    localparam logic [7:0] CONTROL_WR_MASK = 8'hBF;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // Interrupt status fields.
    localparam int IRQ_OVERFLOW = 0;
    localparam int IRQ_SPECIAL = 1;
    localparam int IRQ_W = 2;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    // Prescaler encodings.
    localparam logic [1:0] PS_DIV1 = 2'h0;
    localparam logic [1:0] PS_DIV2 = 2'h1;
    localparam logic [1:0] PS_DIV4 = 2'h2;
    localparam logic [1:0] PS_DIV8 = 2'h3;
endpackage

// [testbench/ext_clock_source.sv]
// Partner model: an external count clock that drives bursts of rising edges.
// Assumes the timer samples this pin with its own 200 MHz clock.
`timescale 1ns/1ps
module ext_clock_source (
    output logic ext_clock_pin // Count clock pin.
);
    // The pin idles low between bursts.
    // The slow half period keeps each edge visible through the synchroniser.
    initial ext_clock_pin = 1'b0;
    task automatic burst(input int n);
        repeat (n) begin
            #23 ext_clock_pin = 1'b1;
            #23 ext_clock_pin = 1'b0;
        end
    endtask
endmodule

// [testbench/test_sixteen_bit_timer_counter.sv]
// Self-checking bench for the 16-bit timer/counter.
// Assumes the register port and the partner clock source in this folder.
`timescale 1ns/1ps
module test_sixteen_bit_timer_counter;
    import timer_one_pkg::*;
    logic clk_sys, rst_b, reg_write, reg_read, ext_clock_pin, trig, sysclk_sec, osc_en, irq;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rd, w;
    logic [15:0] got, cnt;
    int errors = 0, tests_run = 0, cycles = 0, seed = 12783, k, r;
    ////////////////////////////////////////
    // The clock runs at 200 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    timer_one i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .ext_clock_pin(ext_clock_pin), .compare_unit_trigger(trig),
        .sysclk_on_secondary(sysclk_sec), .secondary_osc_enable(osc_en), .irq(irq));
    ext_clock_source i_src (.ext_clock_pin(ext_clock_pin));
    ////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Exact comparison of a register value or a pin.
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // Count comparison where the divider phase leaves a small window.
    task automatic check_range(input string what, input int lo, input int hi,
        input logic [15:0] seen);
        tests_run++;
        if ($isunknown(seen) || seen < lo || seen > hi) begin
            errors++;
            $display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, seen);
        end
    endtask
    // Control read-back: writable bits as written, bit 6 from the clock switch.
    function automatic logic [7:0] ctrl_exp(input logic [7:0] v, input logic s);
        return (v & CONTROL_WR_MASK) | {1'b0, s, 6'h00};
    endfunction
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    // High byte first, so wide mode loads both bytes on the low write.
    task automatic set_count(input logic [15:0] v);
        wr(OFF_COUNT_HIGH, v[15:8]);
        wr(OFF_COUNT_LOW, v[7:0]);
    endtask
    task automatic rd_count();
        rd_reg(OFF_COUNT_LOW);
        got[7:0] = rd;
        rd_reg(OFF_COUNT_HIGH);
        got[15:8] = rd;
    endtask
    // A hang counts as a mismatch.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end
    ////////////////////////////////////////
    // Main sequence.
    initial begin
        {rst_b, reg_write, reg_read, trig, sysclk_sec, reg_addr, reg_wdata} = '0;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd_reg(OFF_CONTROL);
        check("control", 16'h0000, {8'h00, rd});
        check("osc_enable", 16'h0000, {15'h0, osc_en});
        for (k = 0; k < 6; k++) begin
            w = $random(seed) & 8'hFE;
            sysclk_sec <= k[0];
            wr(OFF_CONTROL, w);
            rd_reg(OFF_CONTROL);
            check("control", {8'h00, ctrl_exp(w, k[0])}, {8'h00, rd});
            check("osc_enable", {15'h0, w[BIT_OSC_EN]}, {15'h0, osc_en});
        end
        // Random counts in byte and wide mode, then a lone high-byte write, staged in wide mode only.
        for (k = 0; k < 4; k++) begin
            cnt = $random(seed);
            wr(OFF_CONTROL, {k[0], 7'h00});
            set_count(cnt);
            rd_count();
            check("count", cnt, got);
            wr(OFF_COUNT_HIGH, 8'h5A);
            rd_count();
            check("count", k[0] ? cnt : {8'h5A, cnt[7:0]}, got);
            // A clear between the byte reads shows whether the high byte was latched.
            rd_reg(OFF_COUNT_LOW);
            @(posedge clk_sys);
            trig <= 1'b1;
            @(posedge clk_sys);
            trig <= 1'b0;
            rd_reg(OFF_COUNT_HIGH);
            check("count_high", {8'h00, k[0] ? cnt[15:8] : 8'h00}, {8'h00, rd});
            wr(OFF_IRQ_STATUS, 8'h03);
        end
        // Internal clock through each prescale code: 16 counts expected.
        for (k = 0; k < 4; k++) begin
            wr(OFF_CONTROL, 8'h00);
            set_count(16'h0000);
            r = $random(seed);
            w = {2'b00, k[1:0], 1'b0, r[0], 2'b01};
            wr(OFF_CONTROL, w);
            repeat (64 << k) @(posedge clk_sys);
            wr(OFF_CONTROL, w & 8'hFE);
            rd_count();
            check_range("count", 14, 17, got);
        end
        // Overflow while masked, then unmasked, then cleared.
        wr(OFF_IRQ_MASK, 8'h00);
        set_count(16'hFFFE);
        wr(OFF_CONTROL, 8'h01);
        repeat (20) @(posedge clk_sys);
        wr(OFF_CONTROL, 8'h00);
        rd_count();
        check_range("count", 0, 4, got);
        rd_reg(OFF_IRQ_STATUS);
        check("status", 16'h0001, {8'h00, rd});
        check("irq", 16'h0000, {15'h0, irq});
        wr(OFF_IRQ_MASK, 8'h01);
        #1 check("irq", 16'h0001, {15'h0, irq});
        wr(OFF_IRQ_STATUS, 8'h01);
        #1 check("irq", 16'h0000, {15'h0, irq});
        // Special event trigger clears a stopped count.
        set_count(16'h1234);
        @(posedge clk_sys);
        trig <= 1'b1;
        @(posedge clk_sys);
        trig <= 1'b0;
        rd_count();
        check("count", 16'h0000, got);
        rd_reg(OFF_IRQ_STATUS);
        check("status", 16'h0002, {8'h00, rd});
        // External edges, synchronised and raw: ten edges, ten counts.
        for (k = 0; k < 2; k++) begin
            wr(OFF_CONTROL, 8'h00);
            set_count(16'h0000);
            wr(OFF_CONTROL, {5'h00, k[0], 2'b11});
            i_src.burst(10);
            repeat (10) @(posedge clk_sys);
            wr(OFF_CONTROL, 8'h00);
            rd_count();
            check("count", 16'h000A, got);
        end
        test_done();
    end
endmodule
